// ===== core/cbr_defs.svh
/*
 * constants for the cassette biphase read recovery block: timing counts,
 * prescaler reload, shift register width.
 * assumes inclusion by bare name from the package and the core module.
 */
`ifndef CBR_DEFS_SVH
`define CBR_DEFS_SVH

// system clock period in ns (125 MHz)
`define CBR_CLK_PERIOD_NS 8
// default bit rate in bits per second
`define CBR_BIT_RATE_BPS 1200
// oversampling factor of the prescaler
`define CBR_OVERSAMPLE 16
// prescaler reload count: clocks per read-clock tick, 1e9/(8*1200*16) = 6510
`define CBR_PRESCALE_DIV (1000000000 / (`CBR_CLK_PERIOD_NS * `CBR_BIT_RATE_BPS * `CBR_OVERSAMPLE))
// read-clock tick at which the level is sampled
`define CBR_SAMPLE_TICK 4
// read-clock tick at which timing stops and the detector is re-armed
`define CBR_STOP_TICK 12
// shift register width
`define CBR_SR_WIDTH 8
// prescaler counter width
`define CBR_PRE_WIDTH 16
// bit-timing divider width
`define CBR_DIV_WIDTH 4

`endif

// ===== core/cbr_pkg.sv
/*
 * types for the cassette biphase read recovery block.
 * assumes cbr_defs.svh is on the include path.
 */
`include "cbr_defs.svh"

package cbr_pkg;
    typedef enum logic [0:0] {
        CBR_IDLE = 1'b0,
        CBR_RUN = 1'b1
    } cbr_state_type;
    typedef logic [`CBR_SR_WIDTH-1:0] cbr_byte_type;
    typedef logic [`CBR_PRE_WIDTH-1:0] cbr_pre_type;
    typedef logic [`CBR_DIV_WIDTH-1:0] cbr_div_type;
endpackage

// ===== core/cbr_read_recovery.sv
/*
 * cassette recorder interface, read side: edge detector, self-restarting
 * bit timer, eight-bit receive shift register and a two-entry output buffer.
 * assumes i_tape_data is the digitised playback level, already synchronous
 * to i_mclk, and that the data bus reader samples o_byte on o_byte_valid.
 */
// Operation
// - idle: first input transition starts the read-clock counters
// - four read-clock ticks after start, shift in current input level
// - at tick twelve, divider reset, prescaler preset and held
// - then idle with counters held until next transition restarts them
// - enabled detector pulses on every transition, either direction
// - detector masked from starting transition until tick twelve
// - mid-cell transition near tick eight ignored; equal bits read equal
// - unmasked detector pulses form the shift clock; self-clocking
// - prescaler reloads at sixteen times bit rate, divider counts ticks
// - configuration input optionally inverts input data before sampling
// - eight-bit shift register; byte driven onto bus when read
`timescale 1ns/10ps
`include "cbr_defs.svh"

module cbr_read_recovery (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_tape_data,
    input wire logic i_invert,
    input wire cbr_pkg::cbr_pre_type i_prescale,
    input wire logic i_bus_ready,
    output logic o_byte_valid,
    output cbr_pkg::cbr_byte_type o_byte,
    output cbr_pkg::cbr_byte_type o_shift,
    output logic o_bit_strobe,
    output logic o_overrun,
    output logic o_running
);
    import cbr_pkg::*;

    localparam cbr_div_type SAMPLE_TICK = `CBR_DIV_WIDTH'(`CBR_SAMPLE_TICK);
    localparam cbr_div_type STOP_TICK = `CBR_DIV_WIDTH'(`CBR_STOP_TICK);
    localparam logic [2:0] BITS_LAST = 3'(`CBR_SR_WIDTH - 1);

    // every check in this module runs on the one system clock, off in reset
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    // ************************************************************
    // edge detection and bit timer
    // ************************************************************
    cbr_state_type state;
    cbr_state_type next_state;
    logic prev_level;
    logic next_prev_level;
    cbr_pre_type pre_cnt;
    cbr_pre_type next_pre_cnt;
    cbr_div_type div_cnt;
    cbr_div_type next_div_cnt;
    logic edge_seen;
    logic tick;
    logic data_level;
    logic sample;

    always_comb begin
        edge_seen = i_tape_data ^ prev_level;
        data_level = i_tape_data ^ i_invert;
        // a zero reload would never tick; treat it as one
        tick = (state == CBR_RUN) && (pre_cnt <= 16'h0001);
        next_prev_level = i_tape_data;
        next_state = state;
        next_pre_cnt = pre_cnt;
        next_div_cnt = div_cnt;
        sample = 1'b0;
        case (state)
            CBR_IDLE: begin
                // detector armed only here, so edges inside a cell are lost
                if (edge_seen) begin
                    next_state = CBR_RUN;
                    next_pre_cnt = i_prescale;
                    next_div_cnt = 4'h0;
                end else begin
                    next_pre_cnt = i_prescale;
                    next_div_cnt = 4'h0;
                end
            end
            CBR_RUN: begin
                // edges ignored while running, incl. the mid-cell one
                if (tick) begin
                    next_pre_cnt = i_prescale;
                    next_div_cnt = div_cnt + 4'h1;
                    if (div_cnt + 4'h1 == SAMPLE_TICK) begin
                        sample = 1'b1;
                    end
                    if (div_cnt + 4'h1 == STOP_TICK) begin
                        next_state = CBR_IDLE;
                        next_div_cnt = 4'h0;
                    end
                end else begin
                    next_pre_cnt = pre_cnt - 16'h0001;
                end
            end
            default: begin
                next_state = CBR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state <= CBR_IDLE;
            prev_level <= 1'b0;
            pre_cnt <= 16'h0000;
            div_cnt <= 4'h0;
        end else begin
            state <= next_state;
            prev_level <= next_prev_level;
            pre_cnt <= next_pre_cnt;
            div_cnt <= next_div_cnt;
        end
    end

    // timer: start, sample, stop and masking
    a_idle_edge_starts: assert property (
        (state == CBR_IDLE && edge_seen) |=> (state == CBR_RUN && div_cnt == 4'h0))
        else $error("edge in idle did not start timer");
    a_sample_at_four: assert property (
        sample |-> (state == CBR_RUN && div_cnt == 4'h3 && tick))
        else $error("sample not at tick four");
    a_stop_at_twelve: assert property (
        (state == CBR_RUN && tick && div_cnt == 4'hb) |=> (state == CBR_IDLE && div_cnt == 4'h0))
        else $error("timer did not stop at tick twelve");
    a_idle_held: assert property (
        (state == CBR_IDLE && !edge_seen) |=> (state == CBR_IDLE && pre_cnt == $past(i_prescale)))
        else $error("counters ran while idle");
    a_edge_any_dir: assert property (
        (i_tape_data != $past(i_tape_data)) |-> edge_seen)
        else $error("transition missed by detector");
    a_masked_run: assert property (
        (state == CBR_RUN && !(tick && div_cnt == 4'hb)) |=> state == CBR_RUN)
        else $error("timer left run early");
    a_one_sample_cell: assert property (
        sample |=> (!sample)[*8])
        else $error("two samples too close");
    a_idle_preset: assert property (
        (state == CBR_IDLE) |-> (div_cnt == 4'h0))
        else $error("divider not held clear while idle");

    // ************************************************************
    // shift register and byte assembly
    // ************************************************************
    cbr_byte_type shreg;
    cbr_byte_type next_shreg;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic byte_done;
    logic next_strobe;

    always_comb begin
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        byte_done = 1'b0;
        next_strobe = sample;
        if (sample) begin
            next_shreg = {shreg[`CBR_SR_WIDTH-2:0], data_level};
            next_bit_cnt = bit_cnt + 3'h1;
            byte_done = (bit_cnt == BITS_LAST);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            shreg <= 8'h00;
            bit_cnt <= 3'h0;
            o_bit_strobe <= 1'b0;
        end else begin
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            o_bit_strobe <= next_strobe;
        end
    end

    // shift path
    a_strobe_follows: assert property (
        sample |=> o_bit_strobe)
        else $error("bit strobe not following sample");
    a_strobe_single: assert property (
        o_bit_strobe |=> !o_bit_strobe)
        else $error("bit strobe longer than one cycle");
    a_shift_level: assert property (
        sample |=> shreg[0] == ($past(i_tape_data) ^ $past(i_invert)))
        else $error("wrong bit shifted in");
    a_byte_to_bus: assert property (
        (sample && bit_cnt == BITS_LAST && count == 2'h0) |=> (o_byte_valid && o_byte == shreg))
        else $error("completed byte not offered");

    // ************************************************************
    // two-entry output buffer
    // ************************************************************
    // tape cannot be stalled, so a full buffer not read in that cycle drops the byte and flags it
    cbr_byte_type buf_mem [0:1];
    cbr_byte_type next_buf_mem [0:1];
    logic [1:0] count;
    logic [1:0] next_count;
    logic rd_ptr;
    logic next_rd_ptr;
    logic wr_ptr;
    logic next_wr_ptr;
    logic next_overrun;
    logic push;
    logic pop;
    logic in_ready;

    always_comb begin
        in_ready = (count != 2'h2);
        pop = o_byte_valid && i_bus_ready;
        push = byte_done && (in_ready || pop);
        next_overrun = o_overrun | (byte_done && !push);
        next_count = count + {1'b0, push} - {1'b0, pop};
        next_rd_ptr = rd_ptr ^ pop;
        next_wr_ptr = wr_ptr ^ push;
        for (int i = 0; i < 2; i++) begin
            next_buf_mem[i] = buf_mem[i];
        end
        if (push) begin
            next_buf_mem[wr_ptr] = next_shreg;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            count <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            o_overrun <= 1'b0;
        end else begin
            count <= next_count;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            o_overrun <= next_overrun;
        end
    end

    // one storage register per entry, selected by the pointers
    for (genvar g = 0; g < 2; g++) begin : g_entry
        always_ff @(posedge i_mclk) begin
            if (!i_rst_b) begin
                buf_mem[g] <= 8'h00;
            end else begin
                buf_mem[g] <= next_buf_mem[g];
            end
        end
    end

    // buffer: hold under stall, drop and flag when full
    a_valid_holds: assert property (
        (o_byte_valid && !i_bus_ready) |=> (o_byte_valid && $stable(o_byte)))
        else $error("byte lost under stall");
    a_overrun_sets: assert property (
        (byte_done && count == 2'h2 && !pop) |=> o_overrun)
        else $error("dropped byte not flagged");
    a_overrun_sticky: assert property (
        o_overrun |=> o_overrun)
        else $error("overrun flag cleared outside reset");

    // ************************************************************
    // registered outputs
    // ************************************************************
    logic next_byte_valid;
    cbr_byte_type next_byte;
    logic next_running;

    // look-ahead on the next buffer and timer state keeps every output a plain flop
    always_comb begin
        next_byte_valid = (next_count != 2'h0);
        next_byte = next_buf_mem[next_rd_ptr];
        next_running = (next_state == CBR_RUN);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_byte_valid <= 1'b0;
            o_byte <= 8'h00;
            o_shift <= 8'h00;
            o_running <= 1'b0;
        end else begin
            o_byte_valid <= next_byte_valid;
            o_byte <= next_byte;
            o_shift <= next_shreg;
            o_running <= next_running;
        end
    end

    a_run_output: assert property (
        o_running == (state == CBR_RUN))
        else $error("running output disagrees with timer");

    // ************************************************************
    // cover points
    // ************************************************************
    c_cell_run: cover property (state == CBR_RUN ##1 state == CBR_IDLE);
    c_byte_out: cover property (o_byte_valid && i_bus_ready);
    c_buf_full: cover property (count == 2'h2);
    c_overrun: cover property (!o_overrun ##1 o_overrun);
    c_masked_edge: cover property (state == CBR_RUN && edge_seen);

endmodule // cbr_read_recovery

// ===== bench/cbr_tape_model.sv
/*
 * behavioural playback source for the cassette read recovery block:
 * a digitised biphase level, clocked out at the falling edge of i_mclk.
 * assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/10ps

module cbr_tape_model (
    input wire logic i_mclk,
    output logic o_tape
);
    initial begin
        o_tape = 1'b0;
    end

    task automatic drive(input logic v);
        o_tape = v;
    endtask

    // first half of a cell carries the bit, second half the inverse of the
    // following bit, so equal bits get the mid-cell edge that must be masked;
    // half is in clocks, which lets a caller mimic tape-speed drift
    task automatic send_byte(input logic [7:0] b, input logic nxt, input int half);
        logic [8:0] s;
        s = {b, nxt};
        for (int i = 8; i >= 1; i--) begin
            o_tape = s[i];
            repeat (half) @(negedge i_mclk);
            o_tape = ~s[i-1];
            repeat (half) @(negedge i_mclk);
        end
    endtask
endmodule // cbr_tape_model

// ===== bench/tb_top.sv
/*
 * self-checking bench for cbr_read_recovery, with a playback model.
 * assumes prescale 2, so one bit cell is 32 clocks at nominal speed.
 */
`timescale 1ns/10ps

module tb_top;
    import cbr_pkg::*;
    localparam int P = 2;
    logic i_mclk, i_rst_b, i_invert, i_bus_ready, tape_level;
    cbr_pre_type i_prescale;
    logic o_byte_valid, o_bit_strobe, o_overrun, o_running;
    cbr_byte_type o_byte, o_shift;
    cbr_byte_type rx_q[$];
    int err_count, n_checks;

    cbr_tape_model tape (.i_mclk(i_mclk), .o_tape(tape_level));
    cbr_read_recovery dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_tape_data(tape_level),
        .i_invert(i_invert), .i_prescale(i_prescale), .i_bus_ready(i_bus_ready),
        .o_byte_valid(o_byte_valid), .o_byte(o_byte), .o_shift(o_shift),
        .o_bit_strobe(o_bit_strobe), .o_overrun(o_overrun), .o_running(o_running));

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    // ************
    // bus reader
    // ************
    always @(posedge i_mclk) begin
        if (i_rst_b === 1'b1 && o_byte_valid === 1'b1 && i_bus_ready === 1'b1) begin
            rx_q.push_back(o_byte);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        tape.drive(1'b0);
        i_rst_b = 1'b0;
        repeat (4) @(negedge i_mclk);
        i_rst_b = 1'b1;
        rx_q.delete();
    endtask

    task automatic t_reset;
        do_reset();
        chk(32'({o_byte_valid, o_bit_strobe, o_overrun, o_running, o_shift}), 32'h0);
        $display("reset test done");
    endtask

    // one cell; an edge at tick eight must not restart or resample
    task automatic t_timing;
        int first_run = 0;
        int runs = 0;
        int strobe_at = 0;
        int strobes = 0;
        do_reset();
        tape.drive(1'b1);
        @(posedge i_mclk);
        for (int k = 1; k <= 16 * P + 8; k++) begin
            @(negedge i_mclk);
            if (k == 8 * P) begin
                tape.drive(1'b0);
            end
            if (o_running === 1'b1) begin
                runs++;
                if (first_run == 0) begin
                    first_run = k;
                end
            end
            if (o_bit_strobe === 1'b1) begin
                strobes++;
                strobe_at = k;
            end
        end
        chk(32'(first_run), 32'h1);
        chk(32'(runs), 32'(12 * P));
        chk(32'(strobe_at), 32'(4 * P + 1));
        chk(32'(strobes), 32'h1);
        chk(32'(o_shift), 32'h1);
        $display("timing test done");
    endtask

    task automatic t_bytes;
        do_reset();
        i_bus_ready = 1'b1;
        tape.send_byte(8'ha5, 1'b0, 8 * P);
        tape.send_byte(8'h3c, 1'b1, 8 * P);
        repeat (4) @(negedge i_mclk);
        chk(32'(rx_q.size()), 32'h2);
        chk(32'(rx_q[0]), 32'ha5);
        chk(32'(rx_q[1]), 32'h3c);
        $display("byte test done");
    endtask

    // fast then slow tape, with the sampled level inverted
    task automatic t_speed;
        do_reset();
        i_invert = 1'b1;
        tape.send_byte(8'hc3, 1'b0, 7 * P);
        tape.send_byte(8'h5a, 1'b1, 10 * P);
        repeat (4) @(negedge i_mclk);
        i_invert = 1'b0;
        chk(32'(rx_q[0]), 32'h3c);
        chk(32'(rx_q[1]), 32'ha5);
        $display("speed test done");
    endtask

    // tape cannot be stalled: the third byte is dropped and flagged
    task automatic t_overrun;
        do_reset();
        i_bus_ready = 1'b0;
        tape.send_byte(8'h81, 1'b1, 8 * P);
        tape.send_byte(8'hff, 1'b1, 8 * P);
        tape.send_byte(8'h80, 1'b1, 8 * P);
        chk(32'({o_overrun, o_byte_valid, o_byte}), 32'h381);
        chk(32'(rx_q.size()), 32'h0);
        i_bus_ready = 1'b1;
        repeat (4) @(negedge i_mclk);
        chk(32'({o_overrun, o_byte_valid}), 32'h2);
        chk(32'({rx_q[0], rx_q[1]}), 32'h81ff);
        $display("overrun test done");
    endtask

    // a zero reload acts as one: a sixteen-clock cell still reads back
    task automatic t_zero_pre;
        do_reset();
        i_prescale = 16'h0000;
        tape.send_byte(8'h96, 1'b0, 8);
        repeat (4) @(negedge i_mclk);
        i_prescale = 16'h0002;
        chk(32'(rx_q.size()), 32'h1);
        chk(32'(rx_q[0]), 32'h96);
        $display("zero prescale test done");
    endtask

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ************
    // main sequence and watchdog
    // ************
    initial begin
        i_rst_b = 1'b0;
        i_invert = 1'b0;
        i_bus_ready = 1'b0;
        i_prescale = 16'h0002;
        err_count = 0;
        n_checks = 0;
        @(negedge i_mclk);
        t_reset();
        t_timing();
        t_bytes();
        t_speed();
        t_overrun();
        t_zero_pre();
        report_and_stop();
    end

    // the tests need about 2000 clocks; allow roughly six times that
    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // tb_top
